// [core/ttr_pkg.sv]
// shared constants for the tape transport remote port
package ttr_pkg;

  // core clock rate in hertz
  localparam int unsigned CLK_HZ = 20_000_000;

  // speed wave scaling: 60 hz at 15 ips
  localparam int unsigned SPD_REF_HZ  = 60;
  localparam int unsigned SPD_REF_IPS = 15;
  // wave edges per second for each ips of tape speed
  localparam int unsigned SPD_STEP = 2 * SPD_REF_HZ / SPD_REF_IPS;

  // record lamp flash half period in milliseconds
  localparam int unsigned BLINK_MS  = 250;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

  // register offsets on the plain register port
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h1;
  localparam logic [3:0] REG_MASK  = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;

  // control register fields and reset value
  localparam int unsigned CTRL_LO_SPEED = 0;
  localparam int unsigned CTRL_SRCH_LAT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;

  // event bits of status and mask
  localparam int unsigned EV_PLAY = 0;
  localparam int unsigned EV_STOP = 1;
  localparam int unsigned EV_FFWD = 2;
  localparam int unsigned EV_REW  = 3;
  localparam int unsigned EV_REC  = 4;
  localparam int unsigned EV_ZERO = 5;
  localparam int unsigned EV_W    = 6;
  localparam logic [5:0]  EV_RST  = 6'h00;

  // transport lines of the shared remote bus
  localparam int unsigned RB_PLAY = 0;
  localparam int unsigned RB_STOP = 1;
  localparam int unsigned RB_FFWD = 2;
  localparam int unsigned RB_REW  = 3;
  localparam int unsigned RB_N    = 4;

  // asynchronous input count (bus lines, search, rec, six cmds, pinch)
  localparam int unsigned SYN_N = 13;
  // idle level of each synced input: connector commands rest high on pull-ups
  localparam logic [SYN_N-1:0] SYN_IDLE = 13'h0fc0;

  // transport modes, gray along stop-play-ffwd-rewind-search
  typedef enum logic [2:0] {
    ST_STOP = 3'b000,
    ST_PLAY = 3'b001,
    ST_FFWD = 3'b011,
    ST_REW  = 3'b010,
    ST_SRCH = 3'b110
  } ttr_state_e;

endpackage

// [core/ttr_remote_port.sv]
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps

//Contract
// - bus line driven high while mode active
// - search pulse starts search to zero
// - held search line defers latched play
// - record waits for pinch engaged
// - record lamp flashes while awaiting pinch
// - active low commands, positive logic tallies
// - play hold latches play, no execute
// - fast forward command starts winding forward
// - play command enters play unless held
// - stop command starts stop sequence
// - speed square wave, 60 hz per 15 ips
// - pinch tally high only when engaged
// - speed range tally high at low speed
// - direction tally high moving forward
// - received tallies for each transport command
// - record tally high when record selected
// - record command selects, lamp flashes until pinch
module ttr_remote_port #(
  parameter int unsigned BLINK_CYC = ttr_pkg::BLINK_CYC,
  parameter int unsigned IPS_W     = 6
) (
  // clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_resetn,
  // register port
  input  wire logic [3:0]                i_reg_addr,
  input  wire logic [7:0]                i_reg_wdata,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  output logic      [7:0]                o_reg_rdata,
  output logic                           o_irq,
  // shared remote bus transport lines (play, stop, ffwd, rewind)
  input  wire logic [ttr_pkg::RB_N-1:0]  i_rb_line,
  output logic      [ttr_pkg::RB_N-1:0]  o_rb_line,
  output logic      [ttr_pkg::RB_N-1:0]  o_rb_oe,
  input  wire logic                      i_rb_search,
  input  wire logic                      i_rb_rec_on,
  // synchroniser connector commands, active low
  input  wire logic                      i_hold_n,
  input  wire logic                      i_fast_forward_command_n,
  input  wire logic                      i_play_n,
  input  wire logic                      i_stop_n,
  input  wire logic                      i_rewind_command_n,
  input  wire logic                      i_rec_n,
  // transport sensing
  input  wire logic                      i_pinch_sense,
  input  wire logic                      i_at_zero,
  input  wire logic [IPS_W-1:0]          i_tape_ips,
  // synchroniser connector tallies
  output logic                           o_speed_wave,
  output logic                           o_pinch_tly,
  output logic                           o_lo_speed_tly,
  output logic                           o_dir_tly,
  output logic                           o_rew_tly,
  output logic                           o_ffwd_tly,
  output logic                           o_play_tly,
  output logic                           o_stop_tly,
  output logic                           o_rec_tly,
  // transport and record drive
  output logic                           o_rec_lamp,
  output logic                           o_rec_active,
  output logic      [2:0]                o_xport_mode
);

  // synchroniser stages, every pin passes two flops
  logic [ttr_pkg::SYN_N-1:0] syn1_q;
  logic [ttr_pkg::SYN_N-1:0] syn2_q;
  logic [ttr_pkg::SYN_N-1:0] prev_q;   // previous synced level
  logic [ttr_pkg::SYN_N-1:0] raw;      // gathered pins

  assign raw = {i_pinch_sense, i_rec_n, i_rewind_command_n, i_stop_n,
                i_play_n, i_fast_forward_command_n, i_hold_n,
                i_rb_rec_on, i_rb_search, i_rb_line};

  // one generate loop of two-flop synchronisers
  // reset to each pin's idle level so no false command follows reset
  genvar gi;
  generate
    for (gi = 0; gi < ttr_pkg::SYN_N; gi++) begin : g_sync
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          syn1_q[gi] <= ttr_pkg::SYN_IDLE[gi];
          syn2_q[gi] <= ttr_pkg::SYN_IDLE[gi];
          prev_q[gi] <= ttr_pkg::SYN_IDLE[gi];
        end else begin
          syn1_q[gi] <= raw[gi];
          syn2_q[gi] <= syn1_q[gi];
          prev_q[gi] <= syn2_q[gi];
        end
      end
    end
  endgenerate

  // synced signals by name
  wire [3:0] s_rb_line  = syn2_q[3:0];
  wire       s_rb_srch  = syn2_q[4];
  wire       s_rb_rec   = syn2_q[5];
  wire       s_pinch    = syn2_q[12];
  wire       srch_rise  = syn2_q[4] & ~prev_q[4];

  // active low inputs turned to positive commands
  wire c_hold = ~syn2_q[6];
  wire c_ffwd = ~syn2_q[7];
  wire c_play = ~syn2_q[8];
  wire c_stop = ~syn2_q[9];
  wire c_rew  = ~syn2_q[10];
  wire c_rec  = ~syn2_q[11];

  // state and control registers
  ttr_pkg::ttr_state_e state_q;
  ttr_pkg::ttr_state_e state_d;
  logic       pend_q;                    // latched play waiting
  logic [1:0] ctrl_q;                    // speed and search latch
  logic [5:0] stat_q;                    // sticky events
  logic [5:0] mask_q;                    // event enables
  logic       rec_sel_q;                 // record selected
  logic [ttr_pkg::RB_N-1:0] rb_oe_q;     // bus line drive

  // momentary pulse on an undriven bus line is a command
  wire [ttr_pkg::RB_N-1:0] rb_rise =
    s_rb_line & ~prev_q[3:0] & ~rb_oe_q;

  // merged transport commands from both ports
  wire stop_c = c_stop | rb_rise[ttr_pkg::RB_STOP];
  wire ffwd_c = c_ffwd | rb_rise[ttr_pkg::RB_FFWD];
  wire rew_c  = c_rew  | rb_rise[ttr_pkg::RB_REW];
  wire play_c = c_play | rb_rise[ttr_pkg::RB_PLAY];
  wire wind_c = stop_c | ffwd_c | rew_c;

  // search pulse only where the search latch is fitted
  wire srch_lat = ctrl_q[ttr_pkg::CTRL_SRCH_LAT];
  wire srch_c   = srch_lat & srch_rise;

  // hold from hold input or steady search line
  wire hold = c_hold | (s_rb_srch & ~srch_lat);

  // play latch kept while held, executes when hold clears
  wire play_req = play_c | pend_q;
  wire pend_d   = play_req & hold & ~wind_c;
  wire go_play  = play_req & ~hold;
  wire zero_hit = (state_q == ttr_pkg::ST_SRCH) & i_at_zero;

  // next transport mode, stop first
  always_comb begin
    state_d = state_q;
    if (stop_c) begin
      state_d = ttr_pkg::ST_STOP;
    end else if (rew_c) begin
      state_d = ttr_pkg::ST_REW;
    end else if (ffwd_c) begin
      state_d = ttr_pkg::ST_FFWD;
    end else if (srch_c) begin
      state_d = ttr_pkg::ST_SRCH;
    end else if (go_play) begin
      state_d = ttr_pkg::ST_PLAY;
    end else if (zero_hit) begin
      state_d = ttr_pkg::ST_STOP;
    end
  end

  // mode register and play latch
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ttr_pkg::ST_STOP;
      pend_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q  <= pend_d;
    end
  end

  // mode decode for tallies and bus drive
  wire in_play = (state_d == ttr_pkg::ST_PLAY);
  wire in_ffwd = (state_d == ttr_pkg::ST_FFWD);
  wire in_rew  = (state_d == ttr_pkg::ST_REW) | (state_d == ttr_pkg::ST_SRCH);
  wire in_stop = (state_d == ttr_pkg::ST_STOP);
  wire [3:0] oe_d = {in_rew, in_ffwd, in_stop, in_play};

  // device holds the line high while its mode is in effect
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rb_oe_q <= '0;
    end else begin
      rb_oe_q <= oe_d;
    end
  end
  assign o_rb_oe   = rb_oe_q;
  assign o_rb_line = rb_oe_q;

  // record select: synchroniser low, or bus line held high
  wire rec_sel_d = (rec_sel_q | c_rec | s_rb_rec) & ~stop_c;
  wire rec_act_d = rec_sel_q & s_pinch & in_play;
  wire flashing  = rec_sel_q & ~s_pinch;

  // flash divider, one enable per half period
  logic [$clog2(BLINK_CYC)-1:0] blink_cnt_q;
  logic                         blink_q;
  wire blink_en = (blink_cnt_q == ($clog2(BLINK_CYC))'(BLINK_CYC - 1));

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else begin
      blink_cnt_q <= blink_en ? '0 : blink_cnt_q + 1'b1;
      blink_q     <= blink_q ^ blink_en;
    end
  end
  wire blink_d = blink_q ^ blink_en;

  // record latch, lamp and channel enable
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rec_sel_q    <= 1'b0;
      o_rec_active <= 1'b0;
      o_rec_lamp   <= 1'b0;
    end else begin
      rec_sel_q    <= rec_sel_d;
      o_rec_active <= rec_act_d;
      o_rec_lamp   <= flashing ? blink_d : rec_act_d;
    end
  end

  // positive logic tallies
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pinch_tly    <= 1'b0;
      o_lo_speed_tly <= 1'b0;
      o_dir_tly      <= 1'b0;
      o_rec_tly      <= 1'b0;
      o_xport_mode   <= ttr_pkg::ST_STOP;
    end else begin
      o_pinch_tly    <= s_pinch;
      o_lo_speed_tly <= ctrl_q[ttr_pkg::CTRL_LO_SPEED];
      o_dir_tly      <= in_play | in_ffwd;
      o_rec_tly      <= rec_sel_q;
      o_xport_mode   <= state_d;
    end
  end

  // last received command, one tally at a time
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rew_tly  <= 1'b0;
      o_ffwd_tly <= 1'b0;
      o_play_tly <= 1'b0;
      o_stop_tly <= 1'b0;
    end else if (stop_c | rew_c | ffwd_c | play_c) begin
      o_stop_tly <= stop_c;
      o_rew_tly  <= ~stop_c & rew_c;
      o_ffwd_tly <= ~stop_c & ~rew_c & ffwd_c;
      o_play_tly <= ~wind_c & play_c;
    end
  end

  // speed wave: accumulate tape speed, toggle at each wrap
  logic [24:0] acc_q;
  wire  [24:0] acc_add = 25'(i_tape_ips) * 25'(ttr_pkg::SPD_STEP);
  wire  [24:0] acc_sum = acc_q + acc_add;
  wire         acc_wrap = (acc_sum >= 25'(ttr_pkg::CLK_HZ));

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_q        <= '0;
      o_speed_wave <= 1'b0;
    end else begin
      acc_q        <= acc_wrap ? acc_sum - 25'(ttr_pkg::CLK_HZ) : acc_sum;
      o_speed_wave <= o_speed_wave ^ acc_wrap;
    end
  end

  // register decode
  wire wr_ctrl = i_reg_wr & (i_reg_addr == ttr_pkg::REG_CTRL);
  wire wr_stat = i_reg_wr & (i_reg_addr == ttr_pkg::REG_STAT);
  wire wr_mask = i_reg_wr & (i_reg_addr == ttr_pkg::REG_MASK);

  // events: set wins over write-one clear
  wire [5:0] ev = {zero_hit, rec_act_d & ~o_rec_active,
                   rew_c, ffwd_c, stop_c, play_c};
  wire [5:0] w1c = wr_stat ? i_reg_wdata[5:0] : 6'h00;

  // control, status and mask registers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= ttr_pkg::CTRL_RST;
      stat_q <= ttr_pkg::EV_RST;
      mask_q <= ttr_pkg::EV_RST;
      o_irq  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_reg_wdata[1:0];
      end
      if (wr_mask) begin
        mask_q <= i_reg_wdata[5:0];
      end
      stat_q <= (stat_q & ~w1c) | ev;
      o_irq  <= |(((stat_q & ~w1c) | ev) & mask_q);
    end
  end

  // read mux, unmapped reads zero
  logic [7:0] rd_mux;
  always_comb begin
    case (i_reg_addr)
      ttr_pkg::REG_CTRL:  rd_mux = {6'h00, ctrl_q};
      ttr_pkg::REG_STAT:  rd_mux = {2'h0, stat_q};
      ttr_pkg::REG_MASK:  rd_mux = {2'h0, mask_q};
      ttr_pkg::REG_STATE: rd_mux = {2'h0, s_pinch, rec_sel_q, pend_q, state_q};
      default:            rd_mux = 8'h00;
    endcase
  end

  // read data one cycle after the strobe, only then
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
    end
  end

  // checks on the transport behaviour
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  stop_mode_a: assert property (stop_c |=> state_q == ttr_pkg::ST_STOP)
    else $error("stop command did not stop transport");
  ffwd_mode_a: assert property (
    (ffwd_c && !stop_c && !rew_c) |=> state_q == ttr_pkg::ST_FFWD)
    else $error("fast forward command ignored");
  play_hold_a: assert property (
    (play_c && hold && !wind_c && !srch_c && state_q == ttr_pkg::ST_STOP)
      |=> (state_q == ttr_pkg::ST_STOP) && pend_q)
    else $error("held play executed or not latched");
  play_go_a: assert property (
    (play_c && !hold && !wind_c && !srch_c) |=> state_q == ttr_pkg::ST_PLAY)
    else $error("play command did not enter play");
  srch_go_a: assert property (
    (srch_c && !wind_c) |=> state_q == ttr_pkg::ST_SRCH)
    else $error("search pulse did not start search");
  rec_pinch_a: assert property (o_rec_active |-> o_pinch_tly)
    else $error("record active without pinch");
  rec_flash_a: assert property (
    (flashing && blink_en && $past(flashing)) |=> $changed(o_rec_lamp))
    else $error("record lamp not flashing while waiting");
  bus_drive_a: assert property (
    o_rb_oe[ttr_pkg::RB_PLAY] == (state_q == ttr_pkg::ST_PLAY))
    else $error("play line drive differs from play mode");
  dir_tly_a: assert property (
    o_dir_tly == (state_q inside {ttr_pkg::ST_PLAY, ttr_pkg::ST_FFWD}))
    else $error("direction tally wrong");
  spd_still_a: assert property ((i_tape_ips == '0) |=> $stable(o_speed_wave))
    else $error("speed wave moved with tape still");
  // tallies follow the received command and the record latch
  stop_tly_a: assert property (stop_c |=> o_stop_tly && !o_play_tly)
    else $error("stop tally not shown after stop command");
  rec_clear_a: assert property (stop_c |-> ##2 !o_rec_tly)
    else $error("record tally kept after stop command");

  // main scenarios
  held_play_c: cover property (pend_q ##1 !hold ##1 state_q == ttr_pkg::ST_PLAY);
  rec_on_c:    cover property (flashing ##[1:50] o_rec_active);
  zero_c:      cover property (zero_hit ##1 state_q == ttr_pkg::ST_STOP);
  spd_c:       cover property ($rose(o_speed_wave));
  wind_swap_c: cover property (state_q == ttr_pkg::ST_FFWD ##1 state_q == ttr_pkg::ST_REW);

endmodule

// [tb/ttr_ctl_model.sv]
`timescale 1ns/10ps
// far-side controller: remote bus lines and synchroniser connector
module ttr_ctl_model (
  // clock
  input  wire logic       i_core_clk,
  // device side of the four transport lines
  input  wire logic [3:0] i_dev_oe,
  input  wire logic [3:0] i_dev_line,
  // wired bus level, search, record-on, connector inputs
  output logic      [3:0] o_rb_wire,
  output logic            o_search,
  output logic            o_rec_on,
  output logic      [5:0] o_cmd_n
);
  logic [5:0] drv_q; // lines we pull to +7v: [3:0] transport, 4 search, 5 record-on

  // wired-or of both parties; a released line falls back low
  assign o_rb_wire = drv_q[3:0] | (i_dev_oe & i_dev_line);
  assign o_search  = drv_q[4];
  assign o_rec_on  = drv_q[5];

  // idle: nothing pulled, connector inputs float high on pull-ups
  initial begin
    drv_q   = 6'h00;
    o_cmd_n = 6'h3f;
  end

  // steady level on one bus line
  task automatic drive(input int l, input logic v);
    @(posedge i_core_clk);
    drv_q[l] <= v;
  endtask

  // momentary connection of one bus line to +7v
  task automatic bus_pulse(input int l);
    drive(l, 1'b1);
    repeat (3) @(posedge i_core_clk);
    drv_q[l] <= 1'b0;
  endtask

  // connector input: 0 shorts to ground, 1 lets it float high
  task automatic pin(input int p, input logic v);
    @(posedge i_core_clk);
    o_cmd_n[p] <= v;
  endtask
endmodule

// [tb/test_ttr_remote_port.sv]
`timescale 1ns/10ps
// self-checking bench for the tape transport remote port
module test_ttr_remote_port;
  localparam int unsigned BLINK = 4; // short lamp half period
  localparam int unsigned HALF  = ttr_pkg::CLK_HZ / (ttr_pkg::SPD_STEP * 63); // wave half period
  // ffwd, rewind, stop through the connector
  localparam int         PINS  [3] = '{1, 4, 3};
  localparam logic [2:0] MODES [3] = '{3'h3, 3'h2, 3'h0};
  localparam logic [3:0] OES   [3] = '{4'h4, 4'h8, 4'h2};
  localparam logic [3:0] TLYS  [3] = '{4'h4, 4'h8, 4'h1};
  localparam logic [2:0] DIRS      = 3'b001;

  logic       clk = 1'b0;   // core clock
  logic       resetn = 1'b0; // reset, active low
  logic [3:0] addr = 4'h0;   // register port
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic [3:0] rb_wire, rb_line, rb_oe; // bus lines
  logic       search, rec_on;
  logic [5:0] cmd_n;         // hold, ffwd, play, stop, rewind, record
  logic       pinch = 1'b0;  // transport sensing
  logic       at_zero = 1'b0;
  logic [5:0] ips = 6'h00;
  logic       wave, pinch_tly, lo_tly, dir_tly, rew_tly, ffwd_tly, play_tly, stop_tly;
  logic       rec_tly, lamp, rec_act;
  logic [2:0] mode;
  logic [7:0] d;             // read scratch
  logic       hi, lo, w;     // lamp and wave scratch
  int         num_errors = 0;
  int         checks = 0;
  int         n;

  // clock at 20 mhz
  always #25 clk = ~clk;

  ttr_remote_port #(.BLINK_CYC(BLINK)) dut_u (
    .i_core_clk(clk), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq),
    .i_rb_line(rb_wire), .o_rb_line(rb_line), .o_rb_oe(rb_oe), .i_rb_search(search),
    .i_rb_rec_on(rec_on), .i_hold_n(cmd_n[0]), .i_fast_forward_command_n(cmd_n[1]),
    .i_play_n(cmd_n[2]), .i_stop_n(cmd_n[3]), .i_rewind_command_n(cmd_n[4]),
    .i_rec_n(cmd_n[5]), .i_pinch_sense(pinch), .i_at_zero(at_zero), .i_tape_ips(ips),
    .o_speed_wave(wave), .o_pinch_tly(pinch_tly), .o_lo_speed_tly(lo_tly),
    .o_dir_tly(dir_tly), .o_rew_tly(rew_tly), .o_ffwd_tly(ffwd_tly),
    .o_play_tly(play_tly), .o_stop_tly(stop_tly), .o_rec_tly(rec_tly),
    .o_rec_lamp(lamp), .o_rec_active(rec_act), .o_xport_mode(mode));

  ttr_ctl_model ctl_u (
    .i_core_clk(clk), .i_dev_oe(rb_oe), .i_dev_line(rb_line), .o_rb_wire(rb_wire),
    .o_search(search), .o_rec_on(rec_on), .o_cmd_n(cmd_n));

  // counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // value compare
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // read and compare
  task automatic reg_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    reg_rd(a);
    chk(what, exp, d);
  endtask

  // sync plus state edges, with margin
  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask

  // mode, bus drive, received tallies, direction
  task automatic chk_xport(input logic [2:0] m, input logic [3:0] oe, input logic [3:0] t,
                           input logic dr);
    chk("mode", {5'h00, m}, {5'h00, mode});
    chk("bus drive", {4'h0, oe}, {4'h0, rb_oe});
    chk("tallies", {4'h0, t}, {4'h0, rew_tly, ffwd_tly, play_tly, stop_tly});
    chk("direction", {7'h00, dr}, {7'h00, dir_tly});
    chk("bus level", {4'h0, oe}, {4'h0, rb_line});
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk_xport(3'h0, 4'h2, 4'h0, 1'b0);
    reg_chk("ctrl", 4'h0, 8'h00);
    reg_chk("unmapped", 4'h9, 8'h00);
    // play from the connector, then interrupt raise, mask, clear
    ctl_u.pin(2, 1'b0);
    settle;
    chk_xport(3'h1, 4'h1, 4'h2, 1'b1);
    ctl_u.pin(2, 1'b1);
    reg_chk("status", 4'h1, 8'h01);
    chk("irq masked", 8'h00, {7'h00, irq});
    reg_wr(4'h2, 8'hff);
    reg_chk("mask", 4'h2, 8'h3f);
    chk("irq", 8'h01, {7'h00, irq});
    reg_wr(4'h1, 8'h01);
    reg_chk("status", 4'h1, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    // wind commands and stop
    for (int i = 0; i < 3; i++) begin
      ctl_u.pin(PINS[i], 1'b0);
      settle;
      chk_xport(MODES[i], OES[i], TLYS[i], DIRS[i]);
      ctl_u.pin(PINS[i], 1'b1);
    end
    // play held off, then released
    ctl_u.pin(0, 1'b0);
    ctl_u.pin(2, 1'b0);
    settle;
    chk_xport(3'h0, 4'h2, 4'h2, 1'b0);
    reg_chk("state", 4'h3, 8'h08);
    ctl_u.pin(2, 1'b1);
    ctl_u.pin(0, 1'b1);
    settle;
    chk("mode", 8'h01, {5'h00, mode});
    // stop from a bus pulse
    ctl_u.bus_pulse(1);
    settle;
    chk_xport(3'h0, 4'h2, 4'h1, 1'b0);
    // search latch fitted, low speed
    reg_wr(4'h0, 8'hff);
    reg_chk("ctrl", 4'h0, 8'h03);
    chk("lo speed", 8'h01, {7'h00, lo_tly});
    ctl_u.bus_pulse(4);
    settle;
    chk_xport(3'h6, 4'h8, 4'h1, 1'b0);
    reg_wr(4'h1, 8'h3f);
    @(posedge clk);
    at_zero <= 1'b1;
    @(posedge clk);
    at_zero <= 1'b0;
    settle;
    chk("mode", 8'h00, {5'h00, mode});
    reg_rd(4'h1);
    chk("zero event", 8'h20, d & 8'h20);
    chk("irq", 8'h01, {7'h00, irq});
    // no search latch: held search line defers play
    reg_wr(4'h0, 8'h00);
    ctl_u.drive(4, 1'b1);
    ctl_u.bus_pulse(0);
    settle;
    chk("lo speed", 8'h00, {7'h00, lo_tly});
    reg_chk("state", 4'h3, 8'h08);
    ctl_u.drive(4, 1'b0);
    settle;
    chk("mode", 8'h01, {5'h00, mode});
    // record waits for pinch, lamp flashes meanwhile
    ctl_u.drive(5, 1'b1);
    settle;
    chk("rec tally", 8'h01, {7'h00, rec_tly});
    chk("rec active", 8'h00, {7'h00, rec_act});
    chk("pinch tally", 8'h00, {7'h00, pinch_tly});
    hi = 1'b0;
    lo = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (lamp === 1'b1) hi = 1'b1;
      if (lamp === 1'b0) lo = 1'b1;
    end
    chk("lamp flash", 8'h03, {6'h00, hi, lo});
    @(posedge clk);
    pinch <= 1'b1;
    settle;
    chk("rec active", 8'h01, {7'h00, rec_act});
    chk("lamp", 8'h01, {7'h00, lamp});
    chk("pinch tally", 8'h01, {7'h00, pinch_tly});
    reg_rd(4'h1);
    chk("rec event", 8'h10, d & 8'h10);
    ctl_u.drive(5, 1'b0);
    ctl_u.pin(3, 1'b0);
    settle;
    chk("rec tally", 8'h00, {7'h00, rec_tly});
    ctl_u.pin(3, 1'b1);
    ctl_u.pin(5, 1'b0);
    settle;
    chk("rec tally", 8'h01, {7'h00, rec_tly});
    ctl_u.pin(5, 1'b1);
    // speed wave half period at 63 ips
    @(posedge clk);
    ips <= 6'd63;
    for (int k = 0; k < 2; k++) begin
      w = wave;
      n = 0;
      while (wave === w) begin
        @(posedge clk);
        #1;
        n++;
        if (n > 45000) begin
          chk("wave timeout", 8'h00, 8'h01);
          print_verdict;
        end
      end
    end
    chk("wave half", 8'h01, {7'h00, (n >= HALF && n <= HALF + 1)});
    print_verdict;
  end
endmodule
